// >>> hdl/wdg_top.sv
// Purpose: free-running watchdog with APB control registers
// Assumes: option straps are steady at reset release; halt and wake inputs are pulses
// Notes:   system must feed wdg_rst_n back into presetn
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps
module wdg_top
  import wdg_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // option straps
  input  wire logic        hw_watchdog_option,
  input  wire logic        halt_reset_option,
  // cpu power events
  input  wire logic        halt_exec,
  input  wire logic        ext_irq_wake,
  input  wire logic        timebase_irq_wake,
  // reset request
  output logic             wdg_rst_n
);

  localparam logic [12:0] WAKE_SHORT_CNT = 13'(WAKE_SHORT - 1);
  localparam logic [12:0] WAKE_LONG_CNT  = 13'(WAKE_LONG - 1);
  localparam logic [4:0]  RST_LEN        = 5'(RST_PULSE_CYC);

  typedef struct packed {
    logic        act;
    logic [6:0]  step_count;
    logic [1:0]  timebase_select;
    logic        timebase_irq_enable;
    logic        long_wake;
    logic        opt_taken;
    logic        opt_hw;
    logic        opt_halt_rst;
    wdg_mode_e   mode;
    logic [12:0] wake_cnt;
    logic [4:0]  rst_cnt;
    logic        rst_n;
    logic [31:0] rdata;
  } wdg_state_s;

  wdg_state_s s_q;
  wdg_state_s s_d;
  logic       tick;
  logic       run;
  logic       active;
  logic       acc;
  logic       setup;
  logic       wr;
  logic       mapped;
  logic       fire;

  // ----------------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------------
  assign run = (s_q.mode == MODE_RUN) || (s_q.mode == MODE_HALT_ONE);

  wdg_presc u_presc (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run),
    .tb_sel  (s_q.timebase_select),
    .tick    (tick)
  );

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  assign mapped  = (paddr == ADDR_CTRL) || (paddr == ADDR_ENV) || (paddr == ADDR_STAT);
  assign setup   = psel && !penable;
  assign acc     = psel && penable;
  assign wr      = acc && pwrite && mapped;
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata  = s_q.rdata;

  assign active = s_q.opt_hw || s_q.act;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d  = s_q;
    fire = 1'b0;

    // straps are caught once after release
    if (!s_q.opt_taken) begin
      s_d.opt_taken    = 1'b1;
      s_d.opt_hw       = hw_watchdog_option;
      s_d.opt_halt_rst = halt_reset_option;
    end

    // count steps and rollover
    if (tick && run) begin
      s_d.step_count = s_q.step_count - 7'h01;
      if (s_q.step_count == ROLL_FROM && active) begin
        fire = 1'b1;
      end
      if (s_q.mode == MODE_HALT_ONE) begin
        s_d.mode = MODE_HALTED;
      end
    end

    // register writes
    if (wr && paddr == ADDR_CTRL) begin
      s_d.step_count = pwdata[6:0];
      if (pwdata[CTRL_ACT_BIT]) begin
        s_d.act = 1'b1;
      end
      if ((pwdata[CTRL_ACT_BIT] || s_q.opt_hw) && !pwdata[CTRL_TOP_BIT]) begin
        fire = 1'b1;
      end
    end
    if (wr && paddr == ADDR_ENV) begin
      s_d.timebase_select     = pwdata[1:0];
      s_d.timebase_irq_enable = pwdata[ENV_OIE_BIT];
      s_d.long_wake           = pwdata[ENV_LONG_BIT];
    end

    // halt and wake handling
    unique case (s_q.mode)
      MODE_RUN: begin
        if (halt_exec) begin
          if (s_q.timebase_irq_enable) begin
            s_d.mode = MODE_ACT_HALT;
          end else if (s_q.opt_halt_rst && active) begin
            fire = 1'b1;
          end else begin
            s_d.mode = MODE_HALT_ONE;
          end
        end
      end
      MODE_HALT_ONE, MODE_HALTED: begin
        if (ext_irq_wake) begin
          s_d.mode     = MODE_WAKE_DLY;
          s_d.wake_cnt = s_q.long_wake ? WAKE_LONG_CNT : WAKE_SHORT_CNT;
        end
      end
      MODE_ACT_HALT: begin
        if (ext_irq_wake || timebase_irq_wake) begin
          s_d.mode = MODE_RUN;
        end
      end
      MODE_WAKE_DLY: begin
        if (s_q.wake_cnt == 13'h0000) begin
          s_d.mode = MODE_RUN;
        end else begin
          s_d.wake_cnt = s_q.wake_cnt - 13'h0001;
        end
      end
      default: begin
        s_d.mode = MODE_RUN;
      end
    endcase

    // reset pulse
    if (fire && s_q.rst_n) begin
      s_d.rst_n   = 1'b0;
      s_d.rst_cnt = RST_LEN - 5'h01;
    end else if (!s_q.rst_n) begin
      if (s_q.rst_cnt == 5'h00) begin
        s_d.rst_n = 1'b1;
      end else begin
        s_d.rst_cnt = s_q.rst_cnt - 5'h01;
      end
    end

    // read data captured in the setup phase
    if (setup && !pwrite) begin
      unique case (paddr)
        ADDR_CTRL: s_d.rdata = {24'h000000, s_q.act, s_q.step_count};
        ADDR_ENV:  s_d.rdata = {28'h0000000, s_q.long_wake,
                                s_q.timebase_irq_enable, s_q.timebase_select};
        ADDR_STAT: s_d.rdata = {23'h000000, s_q.mode, ~s_q.rst_n,
                                active, s_q.opt_halt_rst, s_q.opt_hw};
        default:   s_d.rdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{act:                 1'b0,
               step_count:          CTRL_RESET[6:0],
               timebase_select:     ENV_RESET[1:0],
               timebase_irq_enable: ENV_RESET[ENV_OIE_BIT],
               long_wake:           ENV_RESET[ENV_LONG_BIT],
               opt_taken:           1'b0,
               opt_hw:              1'b0,
               opt_halt_rst:        1'b0,
               mode:                MODE_WAKE_DLY,
               wake_cnt:            WAKE_SHORT_CNT,
               rst_cnt:             5'h00,
               rst_n:               1'b1,
               rdata:               32'h00000000};
    end else begin
      s_q <= s_d;
    end
  end

  assign wdg_rst_n = s_q.rst_n;

endmodule

// >>> hdl/wdg_pkg.sv
// Purpose: constants, tables and types shared by the watchdog and its prescaler
// Assumes: oscillator clock and bus clock are the same 50 MHz pclk
// Notes:   offsets are byte addresses on a 32-bit APB bus
package wdg_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int RST_PULSE_NS  = 500;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRESC_PERIOD  = 16384;
  localparam int WAKE_SHORT    = 256;
  localparam int WAKE_LONG     = 4096;
  localparam int TB_MSB [4]    = '{4, 8, 20, 49};
  localparam int TB_LSB [4]    = '{59, 53, 35, 54};

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_ENV     = 12'h004;
  localparam logic [11:0] ADDR_STAT    = 12'h008;
  localparam logic [7:0]  CTRL_RESET   = 8'h7f;
  localparam int          CTRL_ACT_BIT = 7;
  localparam int          CTRL_TOP_BIT = 6;
  localparam logic [6:0]  ROLL_FROM    = 7'h40;
  localparam logic [3:0]  ENV_RESET    = 4'h0;
  localparam int          ENV_OIE_BIT  = 2;
  localparam int          ENV_LONG_BIT = 3;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    MODE_RUN      = 5'b00001,
    MODE_HALT_ONE = 5'b00010,
    MODE_HALTED   = 5'b00100,
    MODE_ACT_HALT = 5'b01000,
    MODE_WAKE_DLY = 5'b10000
  } wdg_mode_e;

  // ----------------------------------------------------------------------
  // prescaler period tables
  // ----------------------------------------------------------------------
  function automatic logic [13:0] wdg_first_len(input logic [1:0] tb);
    return 14'((TB_LSB[tb] + 128) * 64);
  endfunction

  function automatic logic [13:0] wdg_long_len(input logic [1:0] tb);
    return 14'((TB_LSB[tb] + 192) * 64);
  endfunction

  function automatic logic [5:0] wdg_long_every(input logic [1:0] tb);
    return 6'(TB_MSB[tb] / 4);
  endfunction

endpackage

// >>> hdl/wdg_presc.sv
// Purpose: free-running prescaler giving one step pulse per period
// Assumes: run low freezes the phase
// Notes:   some periods are shortened according to the timebase select
`timescale 1ns/100ps
module wdg_presc
  import wdg_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       run,
  input  wire logic [1:0] tb_sel,
  // step pulse
  output logic            tick
);

  typedef struct packed {
    logic [13:0] cnt;
    logic [5:0]  k;
    logic        tick;
  } wdg_presc_s;

  localparam logic [13:0] FIRST_CNT = wdg_first_len(2'b00) - 14'h0001;
  localparam logic [13:0] NORM_CNT  = 14'(PRESC_PERIOD - 1);

  wdg_presc_s s_q;
  wdg_presc_s s_d;

  // ----------------------------------------------------------------------
  // period counting
  // ----------------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (run) begin
      if (s_q.cnt == 14'h0000) begin
        s_d.tick = 1'b1;
        if (s_q.k + 6'h01 >= wdg_long_every(tb_sel)) begin
          s_d.k   = 6'h00;
          s_d.cnt = wdg_long_len(tb_sel) - 14'h0001;
        end else begin
          s_d.k   = s_q.k + 6'h01;
          s_d.cnt = NORM_CNT;
        end
      end else begin
        s_d.cnt = s_q.cnt - 14'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{cnt: FIRST_CNT, k: 6'h00, tick: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule

// >>> verification/wdg_top_sva.sv
// Purpose: port-level assertions for wdg_top
// Assumes: straps steady; halt_exec only in run mode
// Notes:   bound from tb
`timescale 1ns/100ps
module wdg_top_sva
  import wdg_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // straps, events, reset request
  input wire logic        hw_watchdog_option,
  input wire logic        halt_reset_option,
  input wire logic        halt_exec,
  input wire logic        wdg_rst_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       acc, rd_c, act_q, oie_q;
  logic [4:0] low_q;
  assign acc  = psel && penable;
  assign rd_c = acc && !pwrite && paddr == ADDR_CTRL;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= 1'b0;
      oie_q <= 1'b0;
      low_q <= 5'h00;
    end else begin
      if (acc && pwrite && paddr == ADDR_CTRL && pwdata[7]) act_q <= 1'b1;
      if (acc && pwrite && paddr == ADDR_ENV) oie_q <= pwdata[ENV_OIE_BIT];
      low_q <= wdg_rst_n ? 5'h00 : low_q + 5'h01;
    end
  end
  property p_soft;
    acc && pwrite && paddr == ADDR_CTRL && (pwdata[7] || hw_watchdog_option) && !pwdata[6]
      && wdg_rst_n |-> ##[1:2] !wdg_rst_n;
  endproperty
  a_soft: assert property (p_soft) else $error("write did not start reset");
  property p_len;
    $rose(wdg_rst_n) |-> low_q == 5'(RST_PULSE_CYC);
  endproperty
  a_len: assert property (p_len) else $error("reset pulse length wrong");
  property p_max;
    !wdg_rst_n |-> low_q < 5'(RST_PULSE_CYC);
  endproperty
  a_max: assert property (p_max) else $error("reset pulse too long");
  property p_sticky;
    rd_c && act_q |-> prdata[7];
  endproperty
  a_sticky: assert property (p_sticky) else $error("activation bit lost");
  property p_fresh;
    rd_c && !act_q && !hw_watchdog_option |-> !prdata[7];
  endproperty
  a_fresh: assert property (p_fresh) else $error("activation set without write");
  property p_upper;
    rd_c |-> prdata[31:8] == 24'h000000;
  endproperty
  a_upper: assert property (p_upper) else $error("control upper bits not zero");
  property p_hw;
    acc && !pwrite && paddr == ADDR_STAT && hw_watchdog_option |-> prdata[2];
  endproperty
  a_hw: assert property (p_hw) else $error("hardware mode not active");
  property p_halt;
    halt_exec && halt_reset_option && !oie_q && (act_q || hw_watchdog_option) && wdg_rst_n
      |-> ##[1:2] !wdg_rst_n;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not reset");
  property p_ahalt;
    halt_exec && oie_q && wdg_rst_n |=> wdg_rst_n [*8];
  endproperty
  a_ahalt: assert property (p_ahalt) else $error("active halt reset");
endmodule

// >>> verification/tb.sv
// Purpose: self-checking bench for wdg_top
// Assumes: bench drives apb, straps and cpu events
// Notes:   fixed seed; bench resets the block after each pulse
`timescale 1ns/100ps
module tb
  import wdg_pkg::*;
();
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, wdg_rst_n, err;
  logic        hw_opt, hr_opt, halt_exec, ext_wake, tb_wake;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, a;
  int          n_errors, tests_run, seed, lat, len, n_low;
  wdg_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .hw_watchdog_option(hw_opt), .halt_reset_option(hr_opt),
    .halt_exec(halt_exec), .ext_irq_wake(ext_wake), .timebase_irq_wake(tb_wake),
    .wdg_rst_n(wdg_rst_n));
  always #10 pclk = ~pclk;
  always @(posedge pclk) if (wdg_rst_n !== 1'b1) n_low++;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb_wait", n, 32'h1);
  endtask
  task automatic do_reset(input logic hw, input logic hr);
    presetn <= 1'b0;
    hw_opt <= hw;
    hr_opt <= hr;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("mode_after_rst", {27'h0, rd[8:4]}, {27'h0, MODE_WAKE_DLY});
    repeat (300) @(posedge pclk);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("mode_resumed", {27'h0, rd[8:4]}, {27'h0, MODE_RUN});
  endtask
  task automatic evt(input int k);
    @(posedge pclk);
    halt_exec <= (k == 0);
    ext_wake <= (k == 1);
    tb_wake <= (k == 2);
    @(posedge pclk);
    {halt_exec, ext_wake, tb_wake} <= 3'b000;
  endtask
  task automatic pulse(input int lim);
    lat = 0;
    while (wdg_rst_n === 1'b1 && lat < lim) begin
      @(posedge pclk);
      lat++;
    end
    len = 0;
    while (wdg_rst_n === 1'b0 && len < 100) begin
      @(posedge pclk);
      len++;
    end
    chk("pulse_len", len, RST_PULSE_CYC);
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    n_errors++;
    end_of_test();
  end
  initial begin
    logic [31:0] d;
    pclk = 1'b0;
    seed = 46050;
    n_errors = 0;
    tests_run = 0;
    n_low = 0;
    {psel, penable, pwrite, halt_exec, ext_wake, tb_wake} = 6'h00;
    {paddr, pwdata} = 44'h0;
    do_reset(1'b0, 1'b0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl_rst", rd, {24'h0, CTRL_RESET});
    apb(1'b0, ADDR_ENV, 32'h0);
    chk("env_rst", rd, {28'h0, ENV_RESET});
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      apb(1'b1, ADDR_CTRL, {d[31:8], 2'b11, d[5:0]});
      apb(1'b1, ADDR_CTRL, {d[31:8], 2'b01, d[5:0]});
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl_sticky", rd, {24'h0, 2'b11, d[5:0]});
    end
    d = $random(seed);
    apb(1'b1, ADDR_CTRL, {d[31:8], 2'b10, d[5:0]});
    pulse(4);
    chk("soft_lat", {31'h0, lat inside {1, 2}}, 32'h1);
    do_reset(1'b0, 1'b0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl_after_rst", rd, {24'h0, CTRL_RESET});
    apb(1'b1, ADDR_CTRL, 32'h000000c1);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl_load", rd, 32'h000000c1);
    pulse(2 * PRESC_PERIOD + 8);
    chk("roll_lat", {31'h0, lat > 10000 && lat <= 2 * PRESC_PERIOD + 4}, 32'h1);
    do_reset(1'b0, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h000000ff);
    evt(0);
    pulse(4);
    chk("halt_lat", {31'h0, lat inside {1, 2}}, 32'h1);
    do_reset(1'b1, 1'b0);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("stat_hw", {31'h0, rd[0]}, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h0000003f);
    pulse(4);
    chk("hw_lat", {31'h0, lat inside {1, 2}}, 32'h1);
    do_reset(1'b0, 1'b0);
    n_low = 0;
    d = $random(seed);
    apb(1'b1, ADDR_ENV, {28'h0, 2'b10, d[1:0]});
    apb(1'b0, ADDR_ENV, 32'h0);
    chk("env_load", rd, {28'h0, 2'b10, d[1:0]});
    apb(1'b1, ADDR_CTRL, 32'h000000ff);
    evt(0);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("halt_one", {27'h0, rd[8:4]}, {27'h0, MODE_HALT_ONE});
    repeat (12500) @(posedge pclk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("halt_step", rd, 32'h000000fe);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("halted", {27'h0, rd[8:4]}, {27'h0, MODE_HALTED});
    evt(1);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("wake_dly", {27'h0, rd[8:4]}, {27'h0, MODE_WAKE_DLY});
    repeat (4200) @(posedge pclk);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk("wake_run", {27'h0, rd[8:4]}, {27'h0, MODE_RUN});
    chk("halt_no_rst", n_low, 32'h0);
    do_reset(1'b0, 1'b0);
    n_low = 0;
    apb(1'b1, ADDR_ENV, 32'h4);
    evt(0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    a = rd;
    repeat (17000) @(posedge pclk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ahalt_frozen", rd, a);
    evt(1 + ($unsigned($random(seed)) % 2));
    repeat (17000) @(posedge pclk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("resumed", {31'h0, rd[6:0] < a[6:0]}, 32'h1);
    chk("no_rst", n_low, 32'h0);
    end_of_test();
  end
endmodule
bind wdg_top wdg_top_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .hw_watchdog_option(hw_watchdog_option), .halt_reset_option(halt_reset_option),
  .halt_exec(halt_exec), .wdg_rst_n(wdg_rst_n));
